// ===== logic/big_chip_gate.sv
`timescale 1ns/100ps

// Request gating of one parallel interface chip into its two slots
module big_chip_gate (
    input  wire logic [big_pkg::CFG_W-1:0] cfg,
    input  wire logic                      chip_slot0_enable,
    input  wire logic                      chip_slot1_enable,
    input  wire logic                      hs_a_req,
    input  wire logic                      hs_b_req,
    input  wire logic                      out_xfer_req,
    input  wire logic                      in_xfer_req,
    input  wire logic                      port_c_line_three,
    input  wire logic                      port_c_line_zero,
    output logic                           slot0_req,
    output logic                           slot1_req
);

    logic [1:0] a_mode;
    logic       a_basic;
    logic       a_strobed;
    logic       a_bidir;
    logic       b_strobed;
    logic       c_low_in;
    logic       a_src;
    logic       b_src;
    logic       ext_a;
    logic       ext_b;

    // Mode decode
    assign a_mode    = cfg[big_pkg::A_MODE_LSB +: 2];
    assign a_basic   = (a_mode == big_pkg::MODE_BASIC);
    assign a_strobed = (a_mode == big_pkg::MODE_STROBED);
    assign a_bidir   = a_mode[1];
    assign b_strobed = cfg[big_pkg::B_MODE_BIT];
    assign c_low_in  = cfg[big_pkg::C_LOW_IN_BIT];

    // External level inputs on port C, basic mode with low nibble input
    assign ext_a = a_basic & c_low_in & port_c_line_three; // see (RQ8)
    assign ext_b = ~b_strobed & c_low_in & port_c_line_zero; // see (RQ9)

    // Port A source: strobed, bidirectional or external
    assign a_src = (a_strobed & cfg[big_pkg::A_IRQ_EN_BIT] & hs_a_req)
                 | (a_bidir & ((cfg[big_pkg::OUT_IRQ_EN_BIT] & out_xfer_req)
                 | (cfg[big_pkg::IN_IRQ_EN_BIT] & in_xfer_req))) // see (RQ5)
                 | ext_a; // see (RQ11)

    // Port B source: strobed or external
    assign b_src = (b_strobed & cfg[big_pkg::B_IRQ_EN_BIT] & hs_b_req)
                 | ext_b; // see (RQ3)

    // Slot enables gate each chip output
    assign slot0_req = a_src & chip_slot0_enable; // see (RQ6)
    assign slot1_req = b_src & chip_slot1_enable; // see (RQ10)

endmodule : big_chip_gate

// ===== logic/big_pkg.sv
package big_pkg;

    // ****************************************************************
    // Register byte offsets on the Wishbone slave
    // ****************************************************************
    localparam logic [7:0] SLOT_EN_ADR  = 8'h00; // First interrupt register
    localparam logic [7:0] BOARD_ADR    = 8'h04; // Second interrupt register
    localparam logic [7:0] CFG_BASE_ADR = 8'h08; // One word per chip
    localparam logic [7:0] STATUS_ADR   = 8'h18; // Sticky events, write 1
    localparam logic [7:0] MASK_ADR     = 8'h1C; // Gates status to irq
    localparam logic [7:0] RAW_ADR      = 8'h20; // Live request levels
    localparam logic [7:0] CFG_STRIDE   = 8'h04;

    // ****************************************************************
    // Second interrupt register fields
    // ****************************************************************
    localparam int BOARD_EN_BIT = 0;
    localparam int CNT_EN_LSB   = 1;

    // ****************************************************************
    // Per-chip configuration word fields
    // ****************************************************************
    localparam int CFG_W         = 8;
    localparam int A_MODE_LSB    = 0; // Two bits: 0 basic, 1 strobed
    localparam int B_MODE_BIT    = 2; // 0 basic, 1 strobed
    localparam int C_LOW_IN_BIT  = 3; // Port C low nibble is input
    localparam int A_IRQ_EN_BIT  = 4;
    localparam int B_IRQ_EN_BIT  = 5;
    localparam int OUT_IRQ_EN_BIT = 6;
    localparam int IN_IRQ_EN_BIT = 7;

    // Port A mode codes, 2 and 3 both mean bidirectional
    localparam logic [1:0] MODE_BASIC   = 2'h0;
    localparam logic [1:0] MODE_STROBED = 2'h1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;

    // Pins carried per chip into the input synchroniser
    localparam int PINS_PER_CHIP = 6;

endpackage : big_pkg

// ===== logic/big_sync.sv
`timescale 1ns/100ps

// Three-stage pin synchroniser; output moves once stages 2 and 3 agree
module big_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] clean_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] clean_q;
    logic [W-1:0] agree;

    // Only stages 2 and 3 are compared; stage 1 feeds stage 2 alone
    assign agree     = ~(s2_q ^ s3_q);
    assign clean_out = clean_q;

    // Shift chain and filtered output
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_q    <= '0;
            s2_q    <= '0;
            s3_q    <= '0;
            clean_q <= '0;
        end
        else
        begin
            s1_q    <= pin_in;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            clean_q <= (s3_q & agree) | (clean_q & ~agree);
        end
    end

endmodule : big_sync

// ===== logic/big_top.sv
`timescale 1ns/100ps

// Notes on behaviour
// (RQ1) No request reaches the host unless the board-wide enable is set.
// (RQ2) Software clears the board enable first and sets it last.
// (RQ3) In strobed mode the port A and port B enables gate each handshake.
// (RQ4) In bidirectional mode one enable gates output and one input.
// (RQ5) Both bidirectional requests merge into the port A output.
// (RQ6) A chip output reaches the host only with its slot enable set.
// (RQ7) Timer counter outputs can be used as interrupt sources.
// (RQ8) External inputs count only in basic mode with port C low as input.
// (RQ9) Line three serves port A basic mode, line zero serves port B.
// (RQ10) Line three uses slot zero enable, line zero slot one enable.
// (RQ11) An enabled external input requests while it is high.
// (RQ12) The external source holds high until the host masked interrupts.
// (RQ13) Clearing the slot enable or the board enable stops the request.
// (RQ14) The host acknowledges the secondary controller before the primary.
// (RQ15) The host line is the OR of enabled requests, ANDed with the board enable.
module big_top #(
    parameter int N_CHIPS = 4,
    parameter int N_CNT   = 2
) (
    input  wire logic               clk,
    input  wire logic               rst_b,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    output logic                    wb_ack_o,
    input  wire logic [N_CHIPS-1:0] hs_a_req,
    input  wire logic [N_CHIPS-1:0] hs_b_req,
    input  wire logic [N_CHIPS-1:0] out_xfer_req,
    input  wire logic [N_CHIPS-1:0] in_xfer_req,
    input  wire logic [N_CHIPS-1:0] port_c_line_three,
    input  wire logic [N_CHIPS-1:0] port_c_line_zero,
    input  wire logic [N_CNT-1:0]   cnt_out,
    output logic                    host_irq,
    output logic                    irq
);

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int SLOT_W = 2 * N_CHIPS;
    localparam int SRC_W  = SLOT_W + N_CNT;
    localparam int PIN_W  = big_pkg::PINS_PER_CHIP * N_CHIPS + N_CNT;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic [SLOT_W-1:0]         slot_en_q;
    logic                      board_irq_enable_q;
    logic [N_CNT-1:0]          cnt_en_q;
    logic [big_pkg::CFG_W-1:0] cfg_q [N_CHIPS];
    logic [SRC_W-1:0]          status_q;
    logic [SRC_W-1:0]          status_d;
    logic [SRC_W-1:0]          mask_q;
    logic [SRC_W-1:0]          src_prev_q;
    logic                      ack_q;
    logic [31:0]               dat_q;
    logic                      host_irq_q;
    logic                      irq_q;

    logic [PIN_W-1:0]          pin_raw;
    logic [PIN_W-1:0]          pin_clean;
    logic [N_CHIPS-1:0]        s_hs_a;
    logic [N_CHIPS-1:0]        s_hs_b;
    logic [N_CHIPS-1:0]        s_out;
    logic [N_CHIPS-1:0]        s_in;
    logic [N_CHIPS-1:0]        s_three;
    logic [N_CHIPS-1:0]        s_zero;
    logic [N_CNT-1:0]          s_cnt;

    logic [N_CHIPS-1:0]        slot0_req;
    logic [N_CHIPS-1:0]        slot1_req;
    logic [N_CNT-1:0]          cnt_req;
    logic [SRC_W-1:0]          src;
    logic [SRC_W-1:0]          src_rise;

    logic                      req_live;
    logic                      new_req;
    logic                      wr_stb;
    logic                      wr_lane0;
    logic [7:0]                word_adr;
    logic                      hit_slot;
    logic                      hit_board;
    logic                      hit_status;
    logic                      hit_mask;
    logic                      hit_raw;
    logic [N_CHIPS-1:0]        hit_cfg;
    logic [31:0]               cfg_rd [N_CHIPS];
    logic [31:0]               cfg_rd_all;
    logic [31:0]               board_word;
    logic [31:0]               rd_data;
    logic [SRC_W-1:0]          clr_bits;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************

    // Every chip and counter line arrives from outside the clock domain
    assign pin_raw = {cnt_out, port_c_line_zero, port_c_line_three,
                      in_xfer_req, out_xfer_req, hs_b_req, hs_a_req};

    big_sync #(
        .W (PIN_W)
    ) u_sync (
        .clk       (clk),
        .rst_b     (rst_b),
        .pin_in    (pin_raw),
        .clean_out (pin_clean)
    );

    // Split the clean vector back into its groups
    assign s_hs_a  = pin_clean[0*N_CHIPS +: N_CHIPS];
    assign s_hs_b  = pin_clean[1*N_CHIPS +: N_CHIPS];
    assign s_out   = pin_clean[2*N_CHIPS +: N_CHIPS];
    assign s_in    = pin_clean[3*N_CHIPS +: N_CHIPS];
    assign s_three = pin_clean[4*N_CHIPS +: N_CHIPS];
    assign s_zero  = pin_clean[5*N_CHIPS +: N_CHIPS];
    assign s_cnt   = pin_clean[6*N_CHIPS +: N_CNT];

    // ****************************************************************
    // Per-chip request gating
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < N_CHIPS; gi++)
        begin : g_chip
            // Strobed and bidirectional enables live in the chip word
            big_chip_gate u_gate (
                .cfg               (cfg_q[gi]), // see (RQ4)
                .chip_slot0_enable (slot_en_q[2*gi]),
                .chip_slot1_enable (slot_en_q[2*gi+1]),
                .hs_a_req          (s_hs_a[gi]),
                .hs_b_req          (s_hs_b[gi]),
                .out_xfer_req      (s_out[gi]),
                .in_xfer_req       (s_in[gi]),
                .port_c_line_three (s_three[gi]),
                .port_c_line_zero  (s_zero[gi]),
                .slot0_req         (slot0_req[gi]),
                .slot1_req         (slot1_req[gi])
            );

            // Address match and read value of this chip word
            assign hit_cfg[gi] = (word_adr == 8'(big_pkg::CFG_BASE_ADR
                                  + gi * big_pkg::CFG_STRIDE));
            assign cfg_rd[gi]  = hit_cfg[gi] ? 32'(cfg_q[gi]) : '0;

            // Chip word write, low byte lane only
            always_ff @(posedge clk or negedge rst_b)
            begin
                if (!rst_b)
                    cfg_q[gi] <= big_pkg::ZERO_RST[big_pkg::CFG_W-1:0];
                else if (wr_lane0 && hit_cfg[gi])
                    cfg_q[gi] <= wb_dat_i[big_pkg::CFG_W-1:0];
            end
        end
    endgenerate

    // ****************************************************************
    // Source combining
    // ****************************************************************

    // Counter outputs count only with their own enable
    assign cnt_req = s_cnt & cnt_en_q; // see (RQ7)

    // Slot pairs per chip, counters on top
    always_comb
    begin
        src = '0;
        for (int i = 0; i < N_CHIPS; i++)
        begin
            src[2*i]   = slot0_req[i];
            src[2*i+1] = slot1_req[i];
        end
        src[SLOT_W +: N_CNT] = cnt_req;
    end

    // Board line: any enabled source, gated by the board enable
    assign req_live = |src; // see (RQ15)
    assign new_req  = board_irq_enable_q & req_live; // see (RQ1) (RQ13)

    // ****************************************************************
    // Sticky status and summary interrupt
    // ****************************************************************

    // Rising edge of a gated source is an event
    assign src_rise = src & ~src_prev_q;

    // Write one to clear; an event in the same cycle wins
    assign clr_bits = (wr_lane0 && hit_status) ? wb_dat_i[SRC_W-1:0] : '0;
    assign status_d = (status_q & ~clr_bits) | src_rise;

    // ****************************************************************
    // Wishbone slave decode
    // ****************************************************************

    // Word address, byte lanes below it ignored
    assign word_adr   = {wb_adr_i[7:2], 2'b00};
    assign wr_stb     = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
    assign wr_lane0   = wr_stb & wb_sel_i[0];
    assign hit_slot   = (word_adr == big_pkg::SLOT_EN_ADR);
    assign hit_board  = (word_adr == big_pkg::BOARD_ADR);
    assign hit_status = (word_adr == big_pkg::STATUS_ADR);
    assign hit_mask   = (word_adr == big_pkg::MASK_ADR);
    assign hit_raw    = (word_adr == big_pkg::RAW_ADR);

    // Second register: board enable and counter enables
    assign board_word = 32'({cnt_en_q, board_irq_enable_q});

    // OR of all chip words, only the addressed one is non-zero
    always_comb
    begin
        cfg_rd_all = '0;
        for (int i = 0; i < N_CHIPS; i++)
            cfg_rd_all = cfg_rd_all | cfg_rd[i];
    end

    // Read data; unmapped addresses read as zero
    assign rd_data = ({32{hit_slot}}   & 32'(slot_en_q))
                   | ({32{hit_board}}  & board_word)
                   | ({32{hit_status}} & 32'(status_q))
                   | ({32{hit_mask}}   & 32'(mask_q))
                   | ({32{hit_raw}}    & 32'({host_irq_q, src}))
                   | cfg_rd_all;

    // ****************************************************************
    // Bus handshake
    // ****************************************************************

    // One wait state answer, ack drops the cycle after
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_q <= 1'b0;
            dat_q <= big_pkg::ZERO_RST;
        end
        else
        begin
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
            dat_q <= rd_data;
        end
    end

    // ****************************************************************
    // Enable registers
    // ****************************************************************

    // All enables clear at reset, software raises the board enable last
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slot_en_q          <= big_pkg::ZERO_RST[SLOT_W-1:0]; // see (RQ15)
            board_irq_enable_q <= 1'b0; // see (RQ2)
            cnt_en_q           <= big_pkg::ZERO_RST[N_CNT-1:0];
        end
        else if (wr_lane0)
        begin
            if (hit_slot)
                slot_en_q <= wb_dat_i[SLOT_W-1:0];
            if (hit_board)
            begin
                board_irq_enable_q <= wb_dat_i[big_pkg::BOARD_EN_BIT];
                cnt_en_q <= wb_dat_i[big_pkg::CNT_EN_LSB +: N_CNT];
            end
        end
    end

    // ****************************************************************
    // Status, mask and interrupt outputs
    // ****************************************************************

    // Event capture and mask write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            src_prev_q <= big_pkg::ZERO_RST[SRC_W-1:0];
            status_q   <= big_pkg::ZERO_RST[SRC_W-1:0];
            mask_q     <= big_pkg::ZERO_RST[SRC_W-1:0];
        end
        else
        begin
            src_prev_q <= src;
            status_q   <= status_d;
            if (wr_lane0 && hit_mask)
                mask_q <= wb_dat_i[SRC_W-1:0];
        end
    end

    // Host line is a level; the host itself sees its rising edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            host_irq_q <= 1'b0;
            irq_q      <= 1'b0;
        end
        else
        begin
            host_irq_q <= new_req; // see (RQ12)
            irq_q      <= |(status_d & mask_q);
        end
    end

    // Outputs straight from flip-flops
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign host_irq = host_irq_q;
    assign irq      = irq_q;

endmodule : big_top

// ===== tb/big_host_model.sv
`timescale 1ns/100ps

// ****
// Host interrupt controller pair
// ****
module big_host_model (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       host_irq,
    output logic      [7:0] req_cnt_q,
    output logic      [1:0] eoi_q
);
    logic prev_q;

    // Edge detection of the request, then acknowledge sequence
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_q    <= 1'b0;
            req_cnt_q <= 8'h00;
            eoi_q     <= 2'h0;
        end
        else
        begin
            prev_q <= host_irq;
            if (host_irq && !prev_q)
                req_cnt_q <= req_cnt_q + 8'h01;
            eoi_q <= {eoi_q[0], host_irq && !prev_q};
        end
    end
endmodule : big_host_model

// ===== tb/big_top_monitor.sv
`timescale 1ns/100ps

// ****
// Port checker
// ****
module big_top_monitor #(
    parameter int N_CHIPS = 4,
    parameter int N_CNT   = 2
) (
    input wire logic               clk,
    input wire logic               rst_b,
    input wire logic [7:0]         wb_adr_i,
    input wire logic [31:0]        wb_dat_i,
    input wire logic [31:0]        wb_dat_o,
    input wire logic               wb_we_i,
    input wire logic [3:0]         wb_sel_i,
    input wire logic               wb_cyc_i,
    input wire logic               wb_stb_i,
    input wire logic               wb_ack_o,
    input wire logic [N_CHIPS-1:0] hs_a_req,
    input wire logic [N_CHIPS-1:0] hs_b_req,
    input wire logic [N_CHIPS-1:0] out_xfer_req,
    input wire logic [N_CHIPS-1:0] in_xfer_req,
    input wire logic [N_CHIPS-1:0] port_c_line_three,
    input wire logic [N_CHIPS-1:0] port_c_line_zero,
    input wire logic [N_CNT-1:0]   cnt_out,
    input wire logic               host_irq,
    input wire logic               irq
);
    logic [7:0] slot_q;
    logic [2:0] board_q;
    logic [9:0] mask_q;

    // Request taken by the slave, and writes among them
    wire take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr   = take & wb_we_i & wb_sel_i[0];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Shadow of the enable and mask registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            slot_q  <= 8'h00;
            board_q <= 3'h0;
            mask_q  <= 10'h000;
        end
        else if (wr && wb_adr_i[7:2] == 6'h00)
            slot_q <= wb_dat_i[7:0];
        else if (wr && wb_adr_i[7:2] == 6'h01)
            board_q <= wb_dat_i[2:0];
        else if (wr && wb_adr_i[7:2] == 6'h07)
            mask_q <= wb_dat_i[9:0];
    end

    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_timing: assert property (take |=> wb_ack_o)
        else $error("ack missing after request");
    a_no_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_unmapped_zero: assert property (
        take && !wb_we_i && wb_adr_i >= 8'h24 |=> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_board_readback: assert property (
        take && !wb_we_i && wb_adr_i[7:2] == 6'h01
        |=> wb_dat_o[2:0] == $past(board_q)) else $error("board read wrong");
    a_board_gate: assert property (!board_q[0] &&
        !$past(board_q[0]) && !$past(board_q[0], 2) |-> !host_irq)
        else $error("host request with board enable clear");
    a_no_source: assert property (slot_q == 0 &&
        board_q[2:1] == 0 && $past(slot_q) == 0 && $past(board_q[2:1]) == 0
        && $past(slot_q, 2) == 0 && $past(board_q[2:1], 2) == 0 |-> !host_irq)
        else $error("host request with no source enabled");
    a_mask_gate: assert property (mask_q == 0 &&
        $past(mask_q) == 0 && $past(mask_q, 2) == 0 |-> !irq)
        else $error("irq with empty mask");
endmodule : big_top_monitor

bind big_top big_top_monitor #(.N_CHIPS(N_CHIPS), .N_CNT(N_CNT))
    big_top_monitor_i (.clk(clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
    .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .hs_a_req(hs_a_req), .hs_b_req(hs_b_req),
    .out_xfer_req(out_xfer_req), .in_xfer_req(in_xfer_req),
    .port_c_line_three(port_c_line_three),
    .port_c_line_zero(port_c_line_zero), .cnt_out(cnt_out),
    .host_irq(host_irq), .irq(irq));

// ===== tb/big_top_test.sv
`timescale 1ns/100ps

// ****
// Bench for the interrupt gating block
// ****
module big_top_test;
    logic        clk, rst_b, we, cyc, stb, ack, host_irq, irq, board;
    logic [7:0]  adr, slot, req_cnt, req0;
    logic [31:0] dat_i, dat_o, rd, ex;
    logic [3:0]  sel, hsa, hsb, oxr, ixr, pc3, pc0;
    logic [1:0]  cnt, cnt_en, eoi;
    logic [7:0]  cfg [4];
    int          n_errors, n_compared, cycles, i, k;

    big_top big_top_i (.clk(clk), .rst_b(rst_b), .wb_adr_i(adr),
        .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_we_i(we), .wb_sel_i(sel),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .hs_a_req(hsa),
        .hs_b_req(hsb), .out_xfer_req(oxr), .in_xfer_req(ixr),
        .port_c_line_three(pc3), .port_c_line_zero(pc0), .cnt_out(cnt),
        .host_irq(host_irq), .irq(irq));
    big_host_model big_host_model_i (.clk(clk), .rst_b(rst_b),
        .host_irq(host_irq), .req_cnt_q(req_cnt), .eoi_q(eoi));

    // Clock and hang limit
    always #20 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            final_report();
        end
    end

    // One classic bus cycle; read data lands in rd
    task automatic bus(input logic [7:0] a, input logic [31:0] d,
                       input logic w);
        @(posedge clk);
        {cyc, stb, we, adr, dat_i} <= {1'b1, 1'b1, w, a, d};
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask : bus

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report();
        if (n_errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    // Expected live request word from enables and pins
    function automatic logic [31:0] model();
        logic [31:0] r;
        logic [7:0]  c;
        r = 32'h0000_0000;
        for (int j = 0; j < 4; j++)
        begin
            c = cfg[j];
            r[2*j] = slot[2*j]
                & ((c[1:0] == 2'h1 & c[4] & hsa[j])
                | (c[1] & (c[6] & oxr[j] | c[7] & ixr[j]))
                | (c[1:0] == 2'h0 & c[3] & pc3[j]));
            r[2*j+1] = slot[2*j+1]
                & (c[2] & c[5] & hsb[j]
                | !c[2] & c[3] & pc0[j]);
        end
        r[9:8] = cnt & cnt_en;
        r[10] = board & (|r[9:0]);
        return r;
    endfunction : model

    // Main sequence
    initial
    begin
        {clk, rst_b, we, cyc, stb, adr, dat_i} = '0;
        {hsa, hsb, oxr, ixr, pc3, pc0, cnt} = '0;
        sel = 4'hF;
        {n_errors, n_compared, cycles} = '0;
        void'($urandom(32'hfcebc4e8));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (k = 0; k <= 9; k++)
        begin
            bus(8'(4 * k), 32'h0000_0000, 1'b0);
            chk(rd, 32'h0000_0000);
        end
        for (i = 0; i < 40; i++)
        begin
            bus(big_pkg::BOARD_ADR, 32'h0000_0000, 1'b1);
            for (k = 0; k < 4; k++)
            begin
                cfg[k] = 8'($urandom);
                bus(8'(8 + 4 * k), {24'h0, cfg[k]}, 1'b1);
            end
            slot = 8'($urandom);
            {cnt_en, board} = 3'($urandom);
            bus(big_pkg::SLOT_EN_ADR, {24'h0, slot}, 1'b1);
            {hsa, hsb, oxr, ixr, pc3, pc0, cnt} <= 26'($urandom);
            bus(big_pkg::BOARD_ADR, {29'h0, cnt_en, board}, 1'b1);
            repeat (8) @(posedge clk);
            ex = model();
            chk({31'h0, host_irq}, 32'(ex[10]));
            bus(big_pkg::RAW_ADR, 32'h0000_0000, 1'b0);
            chk(rd & 32'h0000_07FF, ex);
        end
        // Two external events on line three: host request, sticky status, mask, clear, then slot enable clear
        bus(big_pkg::BOARD_ADR, 32'h0000_0000, 1'b1);
        {hsa, hsb, oxr, ixr, pc3, pc0, cnt} <= '0;
        bus(big_pkg::CFG_BASE_ADR, 32'h0000_0008, 1'b1);
        bus(big_pkg::SLOT_EN_ADR, 32'h0000_0001, 1'b1);
        bus(big_pkg::MASK_ADR, 32'h0000_0000, 1'b1);
        repeat (8) @(posedge clk);
        bus(big_pkg::STATUS_ADR, 32'h0000_03FF, 1'b1);
        bus(big_pkg::BOARD_ADR, 32'h0000_0001, 1'b1);
        req0 = req_cnt;
        pc3 <= 4'h1;
        repeat (8) @(posedge clk);
        chk({31'h0, host_irq}, 32'h0000_0001);
        chk({24'h0, req_cnt - req0}, 32'h0000_0001);
        // Secondary end-of-interrupt went first, primary one cycle later
        chk({30'h0, eoi}, 32'h0000_0002);
        pc3 <= 4'h0;
        repeat (8) @(posedge clk);
        bus(big_pkg::STATUS_ADR, 32'h0000_0000, 1'b0);
        chk(rd, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        bus(big_pkg::MASK_ADR, 32'h0000_0001, 1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0001);
        bus(big_pkg::STATUS_ADR, 32'h0000_0001, 1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0000_0000);
        pc3 <= 4'h1;
        repeat (8) @(posedge clk);
        bus(big_pkg::SLOT_EN_ADR, 32'h0000_0000, 1'b1);
        repeat (3) @(posedge clk);
        chk({31'h0, host_irq}, 32'h0000_0000);
        final_report();
    end
endmodule : big_top_test
